/* File: shared/ccpu_defines.vh */
`ifndef CCPU_DEFINES_VH
`define CCPU_DEFINES_VH
// Register word indices (printed offsets are indices; address is 4x).
`define CCPU_IDX_A_CONTROL   8'h17
`define CCPU_IDX_B_CONTROL   8'h1d
`define CCPU_IDX_A_DATA_LOW  8'h20
`define CCPU_IDX_A_DATA_HIGH 8'h21
`define CCPU_IDX_B_DATA_LOW  8'h22
`define CCPU_IDX_B_DATA_HIGH 8'h23
`define CCPU_IDX_FLAGS       8'h24
`define CCPU_IDX_TIMER_CTL   8'h25
`define CCPU_IDX_PERIOD      8'h26
`define CCPU_IDX_TMR16_LOW   8'h27
`define CCPU_IDX_TMR16_HIGH  8'h28
// Control register fields.
`define CCPU_MODE_MSB        3
`define CCPU_DUTY_LSB_POS    4
`define CCPU_CONTROL_MASK    8'h3f
`define CCPU_CONTROL_RESET   8'h00
// Mode codes.
`define CCPU_MODE_OFF        4'h0
`define CCPU_MODE_CAP_FALL   4'h4
`define CCPU_MODE_CAP_RISE   4'h5
`define CCPU_MODE_CAP_R4     4'h6
`define CCPU_MODE_CAP_R16    4'h7
`define CCPU_MODE_CMP_SET    4'h8
`define CCPU_MODE_CMP_CLR    4'h9
`define CCPU_MODE_CMP_SWI    4'ha
`define CCPU_MODE_CMP_SPEC   4'hb
// Flag register bits.
`define CCPU_FLAG_T16_OVF    0
`define CCPU_FLAG_A_IRQ      2
`define CCPU_FLAG_B_IRQ      3
// Timer control bits.
`define CCPU_TCTL_T16_RUN    0
`define CCPU_TCTL_T8_RUN     1
`define CCPU_TCTL_ADC_EN     2
// AXI responses.
`define CCPU_RESP_OKAY       2'b00
`define CCPU_RESP_SLVERR     2'b10
`endif

/* File: logic/ccpu_pin_sync.v */
`timescale 1ns/10ps
`default_nettype none
// Two-stage synchroniser with edge pulses taken from the second stage.
module ccpu_pin_sync (
	input  wire i_clk,
	input  wire i_rst,
	input  wire i_pin,
	output wire o_level,
	output wire o_rise,
	output wire o_fall
);
	reg meta_q;
	reg sync_q;
	reg prev_q;

	// The first stage feeds only the second, so no logic sees a metastable value.
	always @(posedge i_clk) begin
		if (i_rst) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			prev_q <= 1'b0;
		end else begin
			meta_q <= i_pin;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	// One-cycle pulses per edge, so each edge counts exactly once.
	assign o_level = sync_q;
	assign o_rise  = sync_q & ~prev_q;
	assign o_fall  = ~sync_q & prev_q;
endmodule // ccpu_pin_sync
`default_nettype wire

/* File: logic/ccpu_unit.v */
`timescale 1ns/10ps
`default_nettype none
`include "ccpu_defines.vh"
// One capture/compare/PWM channel.
module ccpu_unit (
	input  wire        i_clk,
	input  wire        i_rst,
	input  wire [7:0]  i_control,
	input  wire        i_low_we,
	input  wire        i_high_we,
	input  wire [7:0]  i_wdata,
	input  wire        i_pin,
	input  wire [15:0] i_tmr16,
	input  wire [7:0]  i_tmr8,
	input  wire [1:0]  i_tmr8_phase,
	input  wire        i_period_end,
	output reg  [7:0]  o_data_low,
	output reg  [7:0]  o_data_high,
	output reg         o_out,
	output wire        o_event,
	output wire        o_special
);
	wire [3:0] mode = i_control[`CCPU_MODE_MSB:0];
	wire       lvl;
	wire       rise;
	wire       fall;
	reg  [3:0] pre_q;
	reg  [1:0] duty_lsb_q;
	reg        cmp_hit_q;

	ccpu_pin_sync u_sync (
		.i_clk   (i_clk),
		.i_rst   (i_rst),
		.i_pin   (i_pin),
		.o_level (lvl),
		.o_rise  (rise),
		.o_fall  (fall)
	);

	wire is_cap = (mode[3:2] == 2'b01);
	wire is_cmp = (mode[3:2] == 2'b10);
	wire is_pwm = (mode[3:2] == 2'b11);
	// Prescaler counts rising edges; wrap at 4 or 16.
	wire pre_wrap4  = rise & (pre_q[1:0] == 2'h3);
	wire pre_wrap16 = rise & (pre_q == 4'hf);
	reg  cap_evt;
	always @* begin
		case (mode)
			`CCPU_MODE_CAP_FALL: cap_evt = fall;
			`CCPU_MODE_CAP_RISE: cap_evt = rise;
			`CCPU_MODE_CAP_R4:   cap_evt = pre_wrap4;
			`CCPU_MODE_CAP_R16:  cap_evt = pre_wrap16;
			default:             cap_evt = 1'b0;
		endcase
	end
	// Match is taken once per equal period to avoid a repeated flag storm.
	wire match = is_cmp & (i_tmr16 == {o_data_high, o_data_low});
	wire cmp_evt = match & ~cmp_hit_q;
	wire [9:0] duty = {o_data_high, duty_lsb_q};
	wire [9:0] pos  = {i_tmr8, i_tmr8_phase};

	assign o_event   = cap_evt | cmp_evt;
	assign o_special = cmp_evt & (mode == `CCPU_MODE_CMP_SPEC);

	// Prescaler is cleared whenever the unit is off or not capturing.
	always @(posedge i_clk) begin
		if (i_rst || !is_cap) begin
			pre_q     <= 4'h0;
			cmp_hit_q <= 1'b0;
		end else begin
			if (rise) begin
				pre_q <= pre_q + 4'h1;
			end
			cmp_hit_q <= 1'b0;
		end
		if (!i_rst && is_cmp) begin
			cmp_hit_q <= match;
		end
	end

	// Data bytes: software writes, captures overwrite, PWM reloads high.
	always @(posedge i_clk) begin
		if (i_rst) begin
			o_data_low  <= 8'h00;
			o_data_high <= 8'h00;
			duty_lsb_q  <= 2'h0;
		end else if (cap_evt) begin
			o_data_low  <= i_tmr16[7:0];
			o_data_high <= i_tmr16[15:8];
		end else begin
			if (i_low_we) begin
				o_data_low <= i_wdata;
			end
			if (i_high_we && !is_pwm) begin
				o_data_high <= i_wdata;
			end
			if (is_pwm && i_period_end) begin
				o_data_high <= o_data_low;
				duty_lsb_q  <= i_control[5:4];
			end
		end
	end

	// Output latch; the off code forces it low.
	always @(posedge i_clk) begin
		if (i_rst || mode == `CCPU_MODE_OFF) begin
			o_out <= 1'b0;
		end else if (is_pwm) begin
			if (i_period_end) begin
				o_out <= (o_data_low != 8'h00) | (i_control[5:4] != 2'h0);
			end else if (pos == duty) begin
				o_out <= 1'b0;
			end
		end else if (cmp_evt && mode == `CCPU_MODE_CMP_SET) begin
			o_out <= 1'b1;
		end else if (cmp_evt && mode == `CCPU_MODE_CMP_CLR) begin
			o_out <= 1'b0;
		end
	end
	wire unused_lvl = lvl;
endmodule // ccpu_unit
`default_nettype wire

/* File: logic/ccpu_top.v */
`timescale 1ns/10ps
`default_nettype none
`include "ccpu_defines.vh"
module ccpu_top (
	input  wire        i_clk,
	input  wire        i_rst,
	input  wire [11:0] s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [11:0] s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        i_unit_a_pin,
	input  wire        i_unit_b_pin,
	input  wire        i_unit_a_drive,
	input  wire        i_unit_b_drive,
	output wire        o_unit_a_pin,
	output wire        o_unit_b_pin,
	output reg         o_adc_start
);
	reg  [7:0]  ctl_a_q;
	reg  [7:0]  ctl_b_q;
	reg  [3:0]  flags_q;
	reg  [2:0]  tctl_q;
	reg  [7:0]  period_q;
	reg  [15:0] tmr16_q;
	reg  [7:0]  tmr8_q;
	reg  [1:0]  phase_q;
	reg  [11:0] awaddr_q;
	reg  [31:0] wdata_q;
	reg  [3:0]  wstrb_q;
	reg         aw_full_q;
	reg         w_full_q;
	wire [7:0]  a_lo;
	wire [7:0]  a_hi;
	wire [7:0]  b_lo;
	wire [7:0]  b_hi;
	wire        a_evt;
	wire        b_evt;
	wire        a_spec;
	wire        b_spec;
	wire        period_end;

	// Word index from a byte address; misaligned bits are ignored.
	function [7:0] idx_of;
		input [11:0] addr;
		begin
			idx_of = addr[9:2];
		end
	endfunction

	// Write path: address and data latch independently, in either order.
	assign s_axi_awready = ~aw_full_q & ~s_axi_bvalid;
	assign s_axi_wready  = ~w_full_q & ~s_axi_bvalid;
	wire   wr_go  = aw_full_q & w_full_q;
	wire   wr_lane = wr_go & wstrb_q[0];
	wire [7:0] widx = idx_of(awaddr_q);
	wire [7:0] wb   = wdata_q[7:0];
	wire   wr_ctl_a = wr_lane & (widx == `CCPU_IDX_A_CONTROL);
	wire   wr_ctl_b = wr_lane & (widx == `CCPU_IDX_B_CONTROL);
	wire   wr_flags = wr_lane & (widx == `CCPU_IDX_FLAGS);
	function known;
		input [7:0] i;
		begin
			known = (i == `CCPU_IDX_A_CONTROL) | (i == `CCPU_IDX_B_CONTROL) |
				((i >= `CCPU_IDX_A_DATA_LOW) & (i <= `CCPU_IDX_TMR16_HIGH));
		end
	endfunction

	// The pin is sampled even when this unit drives it, so port writes capture.
	wire pin_a = i_unit_a_drive ? o_unit_a_pin : i_unit_a_pin;
	wire pin_b = i_unit_b_drive ? o_unit_b_pin : i_unit_b_pin;

	ccpu_unit u_unit_a (
		.i_clk        (i_clk),
		.i_rst        (i_rst),
		.i_control    (ctl_a_q),
		.i_low_we     (wr_lane & (widx == `CCPU_IDX_A_DATA_LOW)),
		.i_high_we    (wr_lane & (widx == `CCPU_IDX_A_DATA_HIGH)),
		.i_wdata      (wb),
		.i_pin        (pin_a),
		.i_tmr16      (tmr16_q),
		.i_tmr8       (tmr8_q),
		.i_tmr8_phase (phase_q),
		.i_period_end (period_end),
		.o_data_low   (a_lo),
		.o_data_high  (a_hi),
		.o_out        (o_unit_a_pin),
		.o_event      (a_evt),
		.o_special    (a_spec)
	);

	ccpu_unit u_unit_b (
		.i_clk        (i_clk),
		.i_rst        (i_rst),
		.i_control    (ctl_b_q),
		.i_low_we     (wr_lane & (widx == `CCPU_IDX_B_DATA_LOW)),
		.i_high_we    (wr_lane & (widx == `CCPU_IDX_B_DATA_HIGH)),
		.i_wdata      (wb),
		.i_pin        (pin_b),
		.i_tmr16      (tmr16_q),
		.i_tmr8       (tmr8_q),
		.i_tmr8_phase (phase_q),
		.i_period_end (period_end),
		.o_data_low   (b_lo),
		.o_data_high  (b_hi),
		.o_out        (o_unit_b_pin),
		.o_event      (b_evt),
		.o_special    (b_spec)
	);

	// Shared 8-bit period timer with a 2-bit phase for 10-bit duty.
	assign period_end = tctl_q[`CCPU_TCTL_T8_RUN] & (phase_q == 2'h3) &
		(tmr8_q == period_q);
	always @(posedge i_clk) begin
		if (i_rst) begin
			tmr8_q  <= 8'h00;
			phase_q <= 2'h0;
		end else if (tctl_q[`CCPU_TCTL_T8_RUN]) begin
			phase_q <= phase_q + 2'h1;
			if (phase_q == 2'h3) begin
				tmr8_q <= (tmr8_q == period_q) ? 8'h00 : tmr8_q + 8'h01;
			end
		end
	end

	// Shared 16-bit timer; a special-event reset leaves overflow alone.
	wire spec_rst = a_spec | b_spec;
	wire t16_ovf  = tctl_q[`CCPU_TCTL_T16_RUN] & ~spec_rst &
		(tmr16_q == 16'hffff);
	always @(posedge i_clk) begin
		if (i_rst || spec_rst) begin
			tmr16_q <= 16'h0000;
		end else if (tctl_q[`CCPU_TCTL_T16_RUN]) begin
			tmr16_q <= tmr16_q + 16'h0001;
		end
	end

	// Conversion start pulses only from unit b while the converter is enabled.
	always @(posedge i_clk) begin
		if (i_rst) begin
			o_adc_start <= 1'b0;
		end else begin
			o_adc_start <= b_spec & tctl_q[`CCPU_TCTL_ADC_EN];
		end
	end

	// Control and flag registers; hardware sets win over software clears.
	always @(posedge i_clk) begin
		if (i_rst) begin
			ctl_a_q  <= `CCPU_CONTROL_RESET;
			ctl_b_q  <= `CCPU_CONTROL_RESET;
			flags_q  <= 4'h0;
			tctl_q   <= 3'h0;
			period_q <= 8'hff;
		end else begin
			if (wr_ctl_a) begin
				ctl_a_q <= wb & `CCPU_CONTROL_MASK;
			end
			if (wr_ctl_b) begin
				ctl_b_q <= wb & `CCPU_CONTROL_MASK;
			end
			if (wr_lane && widx == `CCPU_IDX_TIMER_CTL) begin
				tctl_q <= wb[2:0];
			end
			if (wr_lane && widx == `CCPU_IDX_PERIOD) begin
				period_q <= wb;
			end
			flags_q <= (wr_flags ? (flags_q & wb[3:0]) : flags_q) |
				{b_evt, a_evt, 1'b0, t16_ovf};
		end
	end

	// AXI write channel handshakes and response.
	always @(posedge i_clk) begin
		if (i_rst) begin
			aw_full_q    <= 1'b0;
			w_full_q     <= 1'b0;
			awaddr_q     <= 12'h000;
			wdata_q      <= 32'h0000_0000;
			wstrb_q      <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `CCPU_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full_q <= 1'b1;
				awaddr_q  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full_q <= 1'b1;
				wdata_q  <= s_axi_wdata;
				wstrb_q  <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_full_q    <= 1'b0;
				w_full_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (known(widx) && awaddr_q[11:10] == 2'h0) ?
					`CCPU_RESP_OKAY : `CCPU_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Read mux; unmapped words read zero with an error response; above 0x3ff the aliased register is read, also with an error response.
	wire [7:0] ridx = idx_of(s_axi_araddr);
	reg  [7:0] rbyte;
	always @* begin
		case (ridx)
			`CCPU_IDX_A_CONTROL:   rbyte = ctl_a_q;
			`CCPU_IDX_B_CONTROL:   rbyte = ctl_b_q;
			`CCPU_IDX_A_DATA_LOW:  rbyte = a_lo;
			`CCPU_IDX_A_DATA_HIGH: rbyte = a_hi;
			`CCPU_IDX_B_DATA_LOW:  rbyte = b_lo;
			`CCPU_IDX_B_DATA_HIGH: rbyte = b_hi;
			`CCPU_IDX_FLAGS:       rbyte = {4'h0, flags_q};
			`CCPU_IDX_TIMER_CTL:   rbyte = {5'h00, tctl_q};
			`CCPU_IDX_PERIOD:      rbyte = period_q;
			`CCPU_IDX_TMR16_LOW:   rbyte = tmr16_q[7:0];
			`CCPU_IDX_TMR16_HIGH:  rbyte = tmr16_q[15:8];
			default:               rbyte = 8'h00;
		endcase
	end
	assign s_axi_arready = ~s_axi_rvalid;
	always @(posedge i_clk) begin
		if (i_rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= `CCPU_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= {24'h00_0000, rbyte};
			s_axi_rresp  <= (known(ridx) && s_axi_araddr[11:10] == 2'h0) ?
				`CCPU_RESP_OKAY : `CCPU_RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule // ccpu_top
`default_nettype wire

/* File: verification/ccpu_pin_model.sv */
`timescale 1ns/10ps
`default_nettype none
// External signal on the unit a capture pin; it idles low between pulses.
module ccpu_pin_model (
	input  wire logic i_clk,
	output var  logic o_pin_a
);
	initial begin
		o_pin_a = 1'b0;
	end

	// Each level is held six cycles so the two-flop synchroniser sees it.
	task automatic pulse(input int n);
		repeat (n) begin
			@(posedge i_clk);
			o_pin_a <= 1'b1;
			repeat (6) @(posedge i_clk);
			o_pin_a <= 1'b0;
			repeat (6) @(posedge i_clk);
		end
	endtask
endmodule // ccpu_pin_model
`default_nettype wire

/* File: verification/ccpu_top_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
`include "ccpu_defines.vh"
// Watches the bus and pins; the mode fields are shadowed from bus writes.
module ccpu_top_asserts (
	input wire logic        i_clk,
	input wire logic        i_rst,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic [11:0] s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        o_unit_a_pin,
	input wire logic        o_adc_start
);
	logic [3:0] mode_a_q;
	logic [3:0] mode_b_q;
	logic       adc_en_q;
	wire        wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready;

	// The shadow assumes address and data are taken at the same edge.
	always @(posedge i_clk) begin
		if (i_rst) begin
			mode_a_q <= 4'h0;
			mode_b_q <= 4'h0;
			adc_en_q <= 1'b0;
		end else if (wr) begin
			if (s_axi_awaddr == 12'h05c)
				mode_a_q <= s_axi_wdata[3:0];
			if (s_axi_awaddr == 12'h074)
				mode_b_q <= s_axi_wdata[3:0];
			if (s_axi_awaddr == 12'h094)
				adc_en_q <= s_axi_wdata[2];
		end
	end

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_rst);

	sequence s_adc;
		o_adc_start ##1 !o_adc_start;
	endsequence
	property p_off_low;
		(mode_a_q == 4'h0) [*4] |-> !o_unit_a_pin;
	endproperty
	property p_swi_stable;
		(mode_a_q == 4'ha) [*4] |=> $stable(o_unit_a_pin);
	endproperty
	property p_rise_mode;
		$rose(o_unit_a_pin) |-> mode_a_q == 4'h8 || mode_a_q[3:2] == 2'b11;
	endproperty
	property p_fall_mode;
		$fell(o_unit_a_pin) |-> mode_a_q == 4'h0 || mode_a_q == 4'h9
			|| mode_a_q[3:2] == 2'b11;
	endproperty
	property p_adc_cause;
		o_adc_start |-> mode_b_q == 4'hb && adc_en_q;
	endproperty
	property p_adc_pulse;
		o_adc_start |-> s_adc;
	endproperty
	property p_ctl_zero;
		s_axi_arvalid && s_axi_arready && (s_axi_araddr == 12'h05c
			|| s_axi_araddr == 12'h074) |=> s_axi_rvalid
			&& s_axi_rdata[31:6] == 26'h0;
	endproperty
	property p_wr_resp;
		wr && s_axi_awaddr == 12'h05c |-> ##2 s_axi_bvalid
			&& s_axi_bresp == `CCPU_RESP_OKAY;
	endproperty

	a_off_low: assert property (p_off_low)
		else $error("unit a pin high while disabled");
	a_swi_stable: assert property (p_swi_stable)
		else $error("unit a pin moved in software interrupt mode");
	a_rise_mode: assert property (p_rise_mode)
		else $error("unit a pin rose outside set or pwm mode");
	a_fall_mode: assert property (p_fall_mode)
		else $error("unit a pin fell outside clear, off or pwm mode");
	a_adc_cause: assert property (p_adc_cause)
		else $error("conversion start without special event mode");
	a_adc_pulse: assert property (p_adc_pulse)
		else $error("conversion start longer than one cycle");
	a_ctl_zero: assert property (p_ctl_zero)
		else $error("control read shows upper bits set");
	a_wr_resp: assert property (p_wr_resp)
		else $error("write response late or not okay");
endmodule // ccpu_top_asserts

bind ccpu_top ccpu_top_asserts ccpu_top_asserts_i (.*);
`default_nettype wire

/* File: verification/ccpu_top_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`include "ccpu_defines.vh"
// Register-level tests of capture, compare and special event behaviour.
module ccpu_top_tb;
	logic        i_clk, i_rst;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_rready, s_axi_awready;
	logic        s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	logic        i_unit_a_pin, i_unit_b_pin, i_unit_a_drive;
	logic        i_unit_b_drive, o_unit_a_pin, o_unit_b_pin, o_adc_start;
	logic [7:0]  d, tl, th;
	logic [15:0] t;
	int          fails = 0, comparisons = 0, cyc = 0, n;

	ccpu_top ccpu_top_i (.*);
	ccpu_pin_model ccpu_pin_model_i (.i_clk(i_clk), .o_pin_a(i_unit_a_pin));

	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end

	task automatic report_and_stop;
		if (fails == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Each channel is released only at the edge that takes it.
	task automatic wr(input logic [7:0] idx, input logic [7:0] v);
		logic ta, tw, tb;
		tb = 1'b0;
		s_axi_awaddr <= {2'b00, idx, 2'b00};
		s_axi_wdata <= {24'h0, v};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!tb) begin
			@(negedge i_clk);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			tb = s_axi_bvalid;
			@(posedge i_clk);
			if (ta)
				s_axi_awvalid <= 1'b0;
			if (tw)
				s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
		@(posedge i_clk);
	endtask

	task automatic rd(input logic [7:0] idx, output logic [7:0] v,
		output logic [1:0] rr);
		logic ta, tr;
		tr = 1'b0;
		s_axi_araddr <= {2'b00, idx, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!tr) begin
			@(negedge i_clk);
			ta = s_axi_arvalid && s_axi_arready;
			tr = s_axi_rvalid;
			v = s_axi_rdata[7:0];
			rr = s_axi_rresp;
			@(posedge i_clk);
			if (ta)
				s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
		@(posedge i_clk);
	endtask

	task automatic rdchk(input string nm, input logic [7:0] idx, exp);
		rd(idx, d, r);
		chk(nm, d, exp);
	endtask

	// The pin is looked at mid-cycle, clear of the launching edge.
	task automatic pin_chk(input logic exp);
		@(negedge i_clk);
		chk("pin_a", o_unit_a_pin, exp);
		@(posedge i_clk);
	endtask

	// The timer is read while stopped, so its count is exact.
	task automatic snap;
		wr(`CCPU_IDX_TIMER_CTL, 8'h00);
		rd(`CCPU_IDX_TMR16_LOW, tl, r);
		rd(`CCPU_IDX_TMR16_HIGH, th, r);
	endtask

	// A hang is cut short well beyond the roughly 1100 cycles needed.
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (cyc == 10000) begin
			fails++;
			report_and_stop();
		end
	end

	initial begin
		i_rst = 1'b1;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 26'h0;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'h1;
		{i_unit_b_pin, i_unit_a_drive, i_unit_b_drive} = 3'h0;
		repeat (16) @(posedge i_clk);
		i_rst <= 1'b0;
		@(posedge i_clk);
		rdchk("a_ctl", `CCPU_IDX_A_CONTROL, 8'h00);
		wr(`CCPU_IDX_A_CONTROL, 8'hff);
		rdchk("a_ctl", `CCPU_IDX_A_CONTROL, 8'h3f);
		wr(`CCPU_IDX_B_CONTROL, 8'hc0);
		rdchk("b_ctl", `CCPU_IDX_B_CONTROL, 8'h00);
		rd(8'h00, d, r);
		chk("unmapped", r, `CCPU_RESP_SLVERR);
		wr(`CCPU_IDX_TIMER_CTL, 8'h01);
		repeat (40) @(posedge i_clk);
		snap();
		// Every capture mode, with one edge short of its count first.
		for (int m = 4; m < 8; m++) begin
			n = (m == 6) ? 4 : (m == 7) ? 16 : 1;
			wr(`CCPU_IDX_A_CONTROL, 8'h00);
			wr(`CCPU_IDX_FLAGS, 8'h00);
			wr(`CCPU_IDX_A_CONTROL, m[7:0]);
			ccpu_pin_model_i.pulse(n - 1);
			rdchk("flags_early", `CCPU_IDX_FLAGS, 8'h00);
			ccpu_pin_model_i.pulse(1);
			rdchk("flags", `CCPU_IDX_FLAGS, 8'h04);
			rdchk("cap_low", `CCPU_IDX_A_DATA_LOW, tl);
			rdchk("cap_high", `CCPU_IDX_A_DATA_HIGH, th);
		end
		rdchk("flags_kept", `CCPU_IDX_FLAGS, 8'h04);
		wr(`CCPU_IDX_TIMER_CTL, 8'h01);
		repeat (25) @(posedge i_clk);
		snap();
		ccpu_pin_model_i.pulse(16);
		rdchk("over_low", `CCPU_IDX_A_DATA_LOW, tl);
		rdchk("over_high", `CCPU_IDX_A_DATA_HIGH, th);
		// Compare match forty counts ahead of the stopped timer.
		t = {th, tl} + 16'd40;
		wr(`CCPU_IDX_A_CONTROL, 8'h00);
		wr(`CCPU_IDX_A_DATA_LOW, t[7:0]);
		wr(`CCPU_IDX_A_DATA_HIGH, t[15:8]);
		wr(`CCPU_IDX_FLAGS, 8'h00);
		wr(`CCPU_IDX_A_CONTROL, 8'h08);
		pin_chk(1'b0);
		wr(`CCPU_IDX_TIMER_CTL, 8'h01);
		repeat (100) begin
			@(negedge i_clk);
			if (o_unit_a_pin === 1'b1)
				break;
		end
		pin_chk(1'b1);
		rdchk("flags_cmp", `CCPU_IDX_FLAGS, 8'h04);
		// Clear-on-match from a high pin; the level holds until the match.
		snap();
		t = {th, tl} + 16'd20;
		wr(`CCPU_IDX_A_DATA_LOW, t[7:0]);
		wr(`CCPU_IDX_A_DATA_HIGH, t[15:8]);
		wr(`CCPU_IDX_A_CONTROL, 8'h09);
		pin_chk(1'b1);
		wr(`CCPU_IDX_TIMER_CTL, 8'h01);
		repeat (40) @(posedge i_clk);
		pin_chk(1'b0);
		wr(`CCPU_IDX_A_CONTROL, 8'h00);
		pin_chk(1'b0);
		// Unit b clears the shared timer; unit a only raises its flag.
		snap();
		t = {th, tl} + 16'd60;
		wr(`CCPU_IDX_B_DATA_LOW, t[7:0]);
		wr(`CCPU_IDX_B_DATA_HIGH, t[15:8]);
		wr(`CCPU_IDX_A_DATA_LOW, 8'h10);
		wr(`CCPU_IDX_A_DATA_HIGH, 8'h00);
		wr(`CCPU_IDX_A_CONTROL, 8'h0a);
		wr(`CCPU_IDX_B_CONTROL, 8'h0b);
		wr(`CCPU_IDX_FLAGS, 8'h00);
		wr(`CCPU_IDX_TIMER_CTL, 8'h05);
		n = 0;
		repeat (150) begin
			@(negedge i_clk);
			if (o_adc_start === 1'b1)
				n++;
		end
		chk("adc_pulses", n, 1);
		@(posedge i_clk);
		snap();
		chk("tmr_cleared", {th, tl} < t, 1'b1);
		rdchk("flags_evt", `CCPU_IDX_FLAGS, 8'h0c);
		pin_chk(1'b0);
		@(negedge i_clk);
		chk("pin_b", o_unit_b_pin, 1'b0);
		@(posedge i_clk);
		// Duty written in PWM mode reaches the high byte only at period end.
		wr(`CCPU_IDX_A_CONTROL, 8'h0c);
		wr(`CCPU_IDX_A_DATA_LOW, 8'h02);
		rdchk("pwm_hold", `CCPU_IDX_A_DATA_HIGH, 8'h00);
		wr(`CCPU_IDX_PERIOD, 8'h03);
		wr(`CCPU_IDX_TIMER_CTL, 8'h02);
		repeat (20) @(posedge i_clk);
		rdchk("pwm_duty", `CCPU_IDX_A_DATA_HIGH, 8'h02);
		report_and_stop();
	end
endmodule // ccpu_top_tb
`default_nettype wire
